// File: src/serdes_defs.svh
// Shared constants for the embedded-clock serializer/deserializer pair
`ifndef SERDES_DEFS_SVH
`define SERDES_DEFS_SVH

// Word and frame geometry
`define WORD_W 10
`define FRAME_W 12
`define START_BIT 1'b1
`define STOP_BIT 1'b0
// Minimum sync burst length in symbols
`define SYNC_MIN 1024
`define SYNC_CNT_W 11
// Consecutive bad clock words that drop lock
`define LOSS_WORDS 4
// Good sync-framed words needed to acquire lock
`define ACQ_WORDS 4
// Payload value of the sync symbol
`define SYNC_WORD 10'h3e0

`endif

// File: src/serdes_pkg.sv
// Types shared by the serializer and deserializer
package serdes_pkg;
    // Serializer word source
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SYNC = 2'b01,
        TX_DATA = 2'b10
    } tx_state_e;
    // Deserializer lock tracking
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_LOCK = 2'b01
    } rx_state_e;
endpackage

// File: src/sync2.sv
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta; // First stage, read only by the second
    logic next_meta;
    logic next_q;

    // Pass-through next values
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    // Registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

// File: src/edge_pick.sv
// Edge detector selecting rising or falling edge of a synchronised clock level
`timescale 1ns/1ps
`default_nettype none
module edge_pick (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Synchronised level and edge choice
    input wire logic lvl_i,
    input wire logic rise_sel_i,
    // One-cycle pulse on the chosen edge
    output logic hit_o
);
    logic prev; // Level one cycle earlier
    logic next_prev;

    // Register the previous level
    always_comb begin
        next_prev = lvl_i;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // High selects rising, low selects falling
    assign hit_o = rise_sel_i ? (lvl_i & ~prev) : (~lvl_i & prev);
endmodule
`default_nettype wire

// File: src/serdes_pair.sv
// Serializer and deserializer pair sharing one bit-rate reference clock
`timescale 1ns/1ps
`default_nettype none
`include "serdes_defs.svh"
module serdes_pair
    import serdes_pkg::*;
(
    // Clock and reset; one bit time per clock
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Serializer parallel side
    input wire logic tx_clock_i,
    input wire logic [`WORD_W-1:0] parallel_data_in_i,
    input wire logic tx_edge_select_i,
    input wire logic serial_output_enable_i,
    input wire logic sync_request_a_i,
    input wire logic sync_request_b_i,
    input wire logic tx_power_down_n_i,
    // Serial link, serializer drive (enable active low)
    output logic serial_out_pos_o,
    output logic serial_out_neg_o,
    output logic serial_out_oe_n_o,
    // Serial link, deserializer receive
    input wire logic serial_in_pos_i,
    input wire logic serial_in_neg_i,
    // Deserializer parallel side
    input wire logic reference_clock_in_i,
    input wire logic rx_edge_select_i,
    input wire logic rx_output_enable_i,
    input wire logic rx_power_down_n_i,
    output logic [`WORD_W-1:0] parallel_data_out_o,
    output logic recovered_clock_o,
    output logic rx_data_oe_n_o,
    output logic acquire_status_n_o,
    output logic acquire_status_oe_n_o,
    // Boundary-scan ports, bypass path only
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_n_o
);
    // ---------------- Input synchronisers ----------------
    logic txclk_s, txsel_s, den_s, sa_s, sb_s, tpd_s;
    logic rin_s, rsel_s, ren_s, rpd_s, reference_clock_in_s;
    logic tck_s, tms_s, tdi_s, trst_s;
    logic [`WORD_W-1:0] din_s;
    logic cap_hit; // Chosen transmit clock edge
    logic ref_hit; // Reference clock rising edge, used only to mark the reference as present

    sync2 u_s_txclk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tx_clock_i), .q_o(txclk_s));
    sync2 u_s_txsel (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tx_edge_select_i), .q_o(txsel_s));
    sync2 u_s_den (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(serial_output_enable_i), .q_o(den_s));
    sync2 u_s_sa (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(sync_request_a_i), .q_o(sa_s));
    sync2 u_s_sb (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(sync_request_b_i), .q_o(sb_s));
    sync2 u_s_tpd (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tx_power_down_n_i), .q_o(tpd_s));
    sync2 u_s_rin (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(serial_in_pos_i & ~serial_in_neg_i), .q_o(rin_s));
    sync2 u_s_rsel (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(rx_edge_select_i), .q_o(rsel_s));
    sync2 u_s_ren (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(rx_output_enable_i), .q_o(ren_s));
    sync2 u_s_rpd (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(rx_power_down_n_i), .q_o(rpd_s));
    sync2 u_s_ref (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(reference_clock_in_i), .q_o(reference_clock_in_s));
    sync2 u_s_tck (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tck_i), .q_o(tck_s));
    sync2 u_s_tms (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tms_i), .q_o(tms_s));
    sync2 u_s_tdi (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(tdi_i), .q_o(tdi_s));
    sync2 u_s_trst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .d_i(~trst_n_i), .q_o(trst_s));

    // One synchroniser per data line
    genvar gi;
    generate
        for (gi = 0; gi < `WORD_W; gi = gi + 1) begin : g_din
            sync2 u_s_din (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
                .d_i(parallel_data_in_i[gi]), .q_o(din_s[gi]));
        end
    endgenerate

    // Pick the transmit clock edge by the select level
    edge_pick u_tx_edge (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .lvl_i(txclk_s), .rise_sel_i(txsel_s), .hit_o(cap_hit));
    // Reference clock edges gate the receiver: no reference, no acquisition
    edge_pick u_ref_edge (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .lvl_i(reference_clock_in_s), .rise_sel_i(1'b1), .hit_o(ref_hit));

    // ---------------- Serializer ----------------
    tx_state_e tx_state, next_tx_state;
    logic [`WORD_W-1:0] in_word, next_in_word;  // Captured parallel word
    logic in_full, next_in_full;                 // Word waiting for framing
    logic [`FRAME_W-1:0] tx_shift, next_tx_shift; // Frame being sent
    logic [3:0] tx_bit, next_tx_bit;            // Bits left in frame
    logic [`SYNC_CNT_W-1:0] sync_cnt, next_sync_cnt; // Sync symbols sent
    logic sync_req;
    logic tx_line, next_tx_line;

    assign sync_req = sa_s | sb_s;

    // Next-state for the transmit path
    always_comb begin
        next_tx_state = tx_state;
        next_in_word = in_word;
        next_in_full = in_full;
        next_tx_shift = tx_shift;
        next_tx_bit = tx_bit;
        next_sync_cnt = sync_cnt;
        next_tx_line = tx_line;
        // Capture on each chosen edge
        if (cap_hit) begin
            next_in_word = din_s;
            next_in_full = 1'b1;
        end
        if (!tpd_s) begin
            // Sleep: halt everything, drop pending word
            next_tx_state = TX_IDLE;
            next_in_full = 1'b0;
            next_tx_bit = 4'h0;
            next_sync_cnt = '0;
        end else if (tx_bit != 4'h0) begin
            // Shift the frame out one bit per clock
            next_tx_line = tx_shift[0];
            next_tx_shift = {1'b0, tx_shift[`FRAME_W-1:1]};
            next_tx_bit = tx_bit - 4'h1;
        end else begin
            // Frame boundary: pick the next word
            case (tx_state)
                TX_SYNC: begin
                    // Finish the minimum burst, then hold while requested
                    if (sync_cnt != `SYNC_CNT_W'(`SYNC_MIN) || sync_req) begin
                        next_tx_shift = {`STOP_BIT, `SYNC_WORD, `START_BIT};
                        next_tx_bit = 4'(`FRAME_W);
                        if (sync_cnt != `SYNC_CNT_W'(`SYNC_MIN)) begin
                            next_sync_cnt = sync_cnt + `SYNC_CNT_W'(1);
                        end
                    end else begin
                        next_tx_state = TX_IDLE;
                        next_sync_cnt = '0;
                    end
                end
                default: begin
                    if (sync_req) begin
                        next_tx_state = TX_SYNC;
                    end else if (in_full) begin
                        // Clock bits wrap the word, data LSB first
                        next_tx_shift = {`STOP_BIT, in_word, `START_BIT};
                        next_tx_bit = 4'(`FRAME_W);
                        next_in_full = cap_hit;
                        next_tx_state = TX_DATA;
                    end else begin
                        next_tx_line = 1'b0; // Idle low between words
                    end
                end
            endcase
        end
    end

    // Transmit registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state <= TX_IDLE;
            in_word <= '0;
            in_full <= 1'b0;
            tx_shift <= '0;
            tx_bit <= 4'h0;
            sync_cnt <= '0;
            tx_line <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            in_word <= next_in_word;
            in_full <= next_in_full;
            tx_shift <= next_tx_shift;
            tx_bit <= next_tx_bit;
            sync_cnt <= next_sync_cnt;
            tx_line <= next_tx_line;
        end
    end

    // Differential drive, enable low means driving
    assign serial_out_pos_o = tx_line;
    assign serial_out_neg_o = ~tx_line;
    assign serial_out_oe_n_o = ~(den_s & tpd_s);

    // ---------------- Deserializer ----------------
    rx_state_e rx_state, next_rx_state;
    logic [`FRAME_W-1:0] rx_shift, next_rx_shift; // Bits of current frame
    logic [3:0] rx_bit, next_rx_bit;              // Bits collected
    logic [2:0] bad_cnt, next_bad_cnt;            // Consecutive bad frames
    logic [2:0] good_cnt, next_good_cnt;          // Consecutive good frames
    logic [`WORD_W-1:0] rx_word, next_rx_word;    // Presented word
    logic rclk, next_rclk;                        // Recovered clock level
    logic ref_seen, next_ref_seen;                // Reference clock present
    logic frame_ok;
    logic [`FRAME_W-1:0] frame;

    assign frame = {rin_s, rx_shift[`FRAME_W-1:1]};
    assign frame_ok = (frame[0] == `START_BIT) && (frame[`FRAME_W-1] == `STOP_BIT);

    // Next-state for the receive path
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = {rin_s, rx_shift[`FRAME_W-1:1]};
        next_rx_bit = rx_bit;
        next_bad_cnt = bad_cnt;
        next_good_cnt = good_cnt;
        next_rx_word = rx_word;
        next_rclk = rclk;
        next_ref_seen = ref_seen | ref_hit;
        if (!rpd_s) begin
            // Sleep: forget lock and the reference
            next_rx_state = RX_HUNT;
            next_rx_bit = 4'h0;
            next_bad_cnt = 3'h0;
            next_good_cnt = 3'h0;
            next_ref_seen = 1'b0;
            next_rclk = 1'b0;
        end else if (rx_state == RX_HUNT) begin
            // Hunt: slide bit by bit; rx_bit counts cycles since the last sync frame
            if (ref_seen && frame_ok && frame[`FRAME_W-2:1] == `SYNC_WORD) begin
                next_good_cnt = good_cnt + 3'h1;
                next_rx_bit = 4'h0;
                if (good_cnt == 3'(`ACQ_WORDS - 1)) begin
                    next_rx_state = RX_LOCK;
                    next_bad_cnt = 3'h0;
                end
            end else if (rx_bit == 4'(`FRAME_W)) begin
                next_good_cnt = 3'h0; // Gap longer than one word time: start over
            end else begin
                next_rx_bit = rx_bit + 4'h1;
            end
        end else begin
            // Locked: the line idles low, so a high at bit 0 opens a frame
            if (rx_bit == 4'h0) begin
                next_rx_bit = {3'h0, rin_s};
            end else if (rx_bit == 4'(`FRAME_W - 1)) begin
                next_rx_bit = 4'h0;
                if (frame_ok) begin
                    next_bad_cnt = 3'h0;
                    next_rx_word = frame[`WORD_W:1];
                end else if (bad_cnt == 3'(`LOSS_WORDS - 1)) begin
                    next_rx_state = RX_HUNT;
                    next_good_cnt = 3'h0;
                end else begin
                    next_bad_cnt = bad_cnt + 3'h1;
                end
            end else begin
                next_rx_bit = rx_bit + 4'h1;
            end
            // Inactive level as a new word appears, active edge a cycle later
            if (rx_bit == 4'(`FRAME_W - 1) && frame_ok) begin
                next_rclk = ~rsel_s;
            end else begin
                next_rclk = rsel_s;
            end
        end
    end

    // Receive registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_state <= RX_HUNT;
            rx_shift <= '0;
            rx_bit <= 4'h0;
            bad_cnt <= 3'h0;
            good_cnt <= 3'h0;
            rx_word <= '0;
            rclk <= 1'b0;
            ref_seen <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_bit <= next_rx_bit;
            bad_cnt <= next_bad_cnt;
            good_cnt <= next_good_cnt;
            rx_word <= next_rx_word;
            rclk <= next_rclk;
            ref_seen <= next_ref_seen;
        end
    end

    // Receive outputs; enable low means driving
    assign parallel_data_out_o = rx_word;
    assign recovered_clock_o = rclk;
    assign acquire_status_n_o = (rx_state != RX_LOCK);
    assign acquire_status_oe_n_o = ~rpd_s;
    assign rx_data_oe_n_o = ~(ren_s && rpd_s && rx_state == RX_LOCK);

    // ---------------- Boundary-scan bypass ----------------
    logic tck_prev, next_tck_prev; // Sampled test clock
    logic byp, next_byp;           // Bypass bit
    logic tdo_q, next_tdo_q;       // Output on falling test clock

    // Single-bit bypass path; tms high loads a zero into the bypass bit instead of tdi
    always_comb begin
        next_tck_prev = tck_s;
        next_byp = byp;
        next_tdo_q = tdo_q;
        if (trst_s) begin
            next_byp = 1'b0;
            next_tdo_q = 1'b0;
        end else if (tck_s && !tck_prev) begin
            next_byp = tdi_s & ~tms_s;
        end else if (!tck_s && tck_prev) begin
            next_tdo_q = byp;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tck_prev <= 1'b0;
            byp <= 1'b0;
            tdo_q <= 1'b0;
        end else begin
            tck_prev <= next_tck_prev;
            byp <= next_byp;
            tdo_q <= next_tdo_q;
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe_n_o = trst_s;
endmodule
`default_nettype wire

// File: sim/serdes_pair_props.sv
// Port-level concurrent checks for the serializer/deserializer pair
`timescale 1ns/1ps
`default_nettype none
module serdes_pair_props (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Controls
    input wire logic serial_output_enable_i,
    input wire logic tx_power_down_n_i,
    input wire logic rx_output_enable_i,
    input wire logic rx_power_down_n_i,
    // Watched outputs
    input wire logic serial_out_pos_o,
    input wire logic serial_out_oe_n_o,
    input wire logic recovered_clock_o,
    input wire logic rx_data_oe_n_o,
    input wire logic acquire_status_n_o,
    input wire logic acquire_status_oe_n_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [3:0] fcnt; // Bit position inside a frame on the line, 0 when idle
    logic [3:0] next_fcnt;
    // Frame tracker; counting starts on any high bit while fcnt is 0, so enabling mid-frame can misalign it
    always_comb begin
        next_fcnt = 4'h0;
        if (!serial_out_oe_n_o) begin
            if (fcnt != 4'h0) begin
                next_fcnt = (fcnt == 4'hb) ? 4'h0 : fcnt + 4'h1;
            end else if (serial_out_pos_o) begin
                next_fcnt = 4'h1;
            end
        end
    end
    // Register the tracker
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fcnt <= 4'h0;
        end else begin
            fcnt <= next_fcnt;
        end
    end
    // Margin of five cycles covers the input synchronisers
    a_serial_off: assert property ((!serial_output_enable_i) [*5] |-> serial_out_oe_n_o)
        else $error("serial pair driven while disabled");
    a_serial_on: assert property ((serial_output_enable_i && tx_power_down_n_i) [*5]
        |-> !serial_out_oe_n_o) else $error("serial pair not driven");
    a_tx_sleep: assert property ((!tx_power_down_n_i) [*5] |-> serial_out_oe_n_o)
        else $error("serializer awake in power down");
    a_rx_sleep: assert property ((!rx_power_down_n_i) [*5]
        |-> acquire_status_oe_n_o && rx_data_oe_n_o) else $error("deserializer awake");
    a_rx_enable_off: assert property ((!rx_output_enable_i) [*5] |-> rx_data_oe_n_o)
        else $error("receive outputs driven while disabled");
    a_unlock_hidden: assert property (acquire_status_n_o [*2] |-> rx_data_oe_n_o)
        else $error("outputs driven while unlocked");
    a_stop_low: assert property (fcnt == 4'hb |-> !serial_out_pos_o)
        else $error("stop bit not low");
    // Loss of lock needs four bad words, so a fresh lock holds for a while
    a_lock_hold: assert property ($fell(acquire_status_n_o)
        |-> (!acquire_status_n_o || !rx_power_down_n_i) [*8]) else $error("lock dropped early");
    a_rclk_period: assert property ($rose(recovered_clock_o)
        |=> (!$rose(recovered_clock_o)) [*8]) else $error("recovered clock too fast");
    // Main scenarios reached
    c_lock: cover property ($fell(acquire_status_n_o));
    c_stop: cover property (fcnt == 4'hb);
    c_rx_on: cover property (!rx_data_oe_n_o && $rose(recovered_clock_o));
endmodule
bind serdes_pair serdes_pair_props props (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .serial_output_enable_i(serial_output_enable_i), .tx_power_down_n_i(tx_power_down_n_i),
    .rx_output_enable_i(rx_output_enable_i), .rx_power_down_n_i(rx_power_down_n_i),
    .serial_out_pos_o(serial_out_pos_o), .serial_out_oe_n_o(serial_out_oe_n_o),
    .recovered_clock_o(recovered_clock_o), .rx_data_oe_n_o(rx_data_oe_n_o),
    .acquire_status_n_o(acquire_status_n_o), .acquire_status_oe_n_o(acquire_status_oe_n_o)
);
`default_nettype wire

// File: sim/word_partner.sv
// Parallel-side system model: word source, word sink and reference clock
`timescale 1ns/1ps
`default_nettype none
`include "serdes_defs.svh"
module word_partner (
    // Bit clock
    input wire logic ref_clk_i,
    // Source side
    input wire logic tx_edge_select_i,
    output logic tx_clock_o,
    output logic [`WORD_W-1:0] data_o,
    output logic reference_clock_o,
    // Sink side
    input wire logic rx_edge_select_i,
    input wire logic rx_data_oe_n_i,
    input wire logic recovered_clock_i,
    input wire logic [`WORD_W-1:0] rx_word_i
);
    logic [`WORD_W-1:0] rx_q[$]; // Words taken at the selected strobe edge
    logic rclk_d; // Strobe level one cycle back
    // Reference clock runs free, unrelated in phase to the bit clock
    initial begin
        tx_clock_o = 1'b0;
        data_o = 10'h000;
        rclk_d = 1'b0;
        reference_clock_o = 1'b0;
        forever #17 reference_clock_o = ~reference_clock_o;
    end
    // Word clock is scaled down so each capture clears the synchronisers; gap slows the source
    task automatic send_word(input logic [`WORD_W-1:0] w, input int gap);
        if (tx_clock_o !== !tx_edge_select_i) begin
            @(negedge ref_clk_i) tx_clock_o = !tx_edge_select_i; // Park, a non-capturing edge
            repeat (4) @(negedge ref_clk_i);
        end
        @(negedge ref_clk_i) data_o = w;
        repeat (4 + gap) @(negedge ref_clk_i);
        tx_clock_o = tx_edge_select_i;
        repeat (8) @(negedge ref_clk_i);
        tx_clock_o = !tx_edge_select_i;
        repeat (4) @(negedge ref_clk_i);
    endtask
    // Sink keeps data words only, sampled where outputs have settled
    always @(negedge ref_clk_i) begin
        if (!rx_data_oe_n_i && recovered_clock_i !== rclk_d &&
            recovered_clock_i === rx_edge_select_i && rx_word_i !== `SYNC_WORD) begin
            rx_q.push_back(rx_word_i);
        end
        rclk_d = recovered_clock_i;
    end
endmodule
`default_nettype wire

// File: sim/serdes_pair_tb.sv
// Self-checking bench for the serializer/deserializer pair
`timescale 1ns/1ps
`default_nettype none
`include "serdes_defs.svh"
module serdes_pair_tb;
    logic ref_clk, sys_rst, tx_clock, tx_sel, ser_en, sync_a, sync_b, tx_pd_n;
    logic out_pos, out_neg, out_oe_n, in_pos, in_neg, reference_clock_in, rx_sel, rx_en, rx_pd_n;
    logic rclk, rx_oe_n, acq_n, acq_oe_n, tck, tdi, trst_n, tdo, tdo_oe_n;
    logic [9:0] din, dout, sh;
    logic [9:0] exp_q[$], tx_got[$];
    logic [9:0] corner [4] = '{10'h000, 10'h3ff, 10'h001, 10'h200}; // Edge patterns first
    int err_count = 0, check_count = 0, sync_cnt = 0, st = 0;
    // Released pair rests on failsafe bias: positive high, negative low
    assign in_pos = out_oe_n ? 1'b1 : out_pos;
    assign in_neg = out_oe_n ? 1'b0 : out_neg;
    serdes_pair dut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .tx_clock_i(tx_clock),
        .parallel_data_in_i(din), .tx_edge_select_i(tx_sel), .serial_output_enable_i(ser_en),
        .sync_request_a_i(sync_a), .sync_request_b_i(sync_b), .tx_power_down_n_i(tx_pd_n),
        .serial_out_pos_o(out_pos), .serial_out_neg_o(out_neg), .serial_out_oe_n_o(out_oe_n),
        .serial_in_pos_i(in_pos), .serial_in_neg_i(in_neg), .reference_clock_in_i(reference_clock_in),
        .rx_edge_select_i(rx_sel), .rx_output_enable_i(rx_en), .rx_power_down_n_i(rx_pd_n),
        .parallel_data_out_o(dout), .recovered_clock_o(rclk), .rx_data_oe_n_o(rx_oe_n),
        .acquire_status_n_o(acq_n), .acquire_status_oe_n_o(acq_oe_n), .tck_i(tck),
        .tms_i(1'b0), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n));
    word_partner partner (.ref_clk_i(ref_clk), .tx_edge_select_i(tx_sel), .tx_clock_o(tx_clock),
        .data_o(din), .reference_clock_o(reference_clock_in), .rx_edge_select_i(rx_sel),
        .rx_data_oe_n_i(rx_oe_n), .recovered_clock_i(rclk), .rx_word_i(dout));
    // 40 MHz bit clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Count a comparison, report a miss at once
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // Random data word that never looks like a sync symbol
    function automatic logic [9:0] rnd_word();
        logic [9:0] w;
        w = 10'($urandom);
        return (w === `SYNC_WORD) ? ~w : w;
    endfunction
    // Two word lists agree in length and in every bit
    function automatic bit same_q(input logic [9:0] a[$], input logic [9:0] b[$]);
        if (a.size() != b.size()) return 0;
        foreach (a[i]) if (a[i] !== b[i]) return 0;
        return 1;
    endfunction
    // Line decoder: start high, ten bits low first, stop low
    always @(negedge ref_clk) begin
        if (out_oe_n !== 1'b0) begin
            st = 0;
        end else if (st == 0) begin
            st = (out_pos === 1'b1) ? 1 : 0;
        end else if (st <= 10) begin
            sh[st-1] = out_pos;
            st++;
        end else begin
            check(out_pos === 1'b0 && out_neg === 1'b1, "stop bit");
            if (sh === `SYNC_WORD) sync_cnt++;
            else tx_got.push_back(sh);
            st = 0;
        end
    end
    // Sync burst on one request input, then a word stream on the chosen edges
    task automatic run_words(input logic tsel, input logic rsel, input logic use_b,
                             input int hold, input int min_sync);
        logic [9:0] w;
        @(negedge ref_clk);
        tx_sel = tsel;
        rx_sel = rsel;
        sync_cnt = 0;
        if (use_b) sync_b = 1'b1;
        else sync_a = 1'b1;
        repeat (hold) @(negedge ref_clk);
        sync_a = 1'b0;
        sync_b = 1'b0;
        for (int i = 0; i < 20000 && sync_cnt < min_sync; i++) @(negedge ref_clk);
        check(sync_cnt >= min_sync, "sync burst too short");
        check(acq_n === 1'b0 && rx_oe_n === 1'b0, "no lock after sync");
        exp_q = {};
        tx_got = {};
        partner.rx_q = {};
        for (int i = 0; i < 16; i++) begin
            w = (i < 4) ? corner[i] : rnd_word();
            exp_q.push_back(w);
            partner.send_word(w, $urandom_range(3, 0));
        end
        repeat (40) @(negedge ref_clk);
        check(same_q(tx_got, exp_q), "serial words differ");
        check(same_q(partner.rx_q, exp_q), "received words differ");
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the roughly 30000 cycles the tests take
    initial begin
        repeat (60000) @(negedge ref_clk);
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end
    // Main sequence
    initial begin
        {tx_sel, ser_en, tx_pd_n, rx_sel, rx_en, rx_pd_n} = 6'h3f;
        {sync_a, sync_b, tck, tdi, trst_n} = 5'h1;
        sys_rst = 1'b1;
        void'($urandom(32'h82309acc));
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(acq_n === 1'b1 && rx_oe_n === 1'b1, "locked out of reset");
        $display("test reset done");
        run_words(1'b1, 1'b1, 1'b0, 4, `SYNC_MIN);
        $display("test rising edges done");
        run_words(1'b0, 1'b0, 1'b1, 14400, 1095);
        $display("test falling edges and held sync done");
        @(negedge ref_clk) sync_a = 1'b1;
        repeat (4) @(negedge ref_clk);
        sync_a = 1'b0;
        for (int i = 0; i < 200 && acq_n !== 1'b0; i++) @(negedge ref_clk);
        rx_en = 1'b0;
        repeat (6) @(negedge ref_clk);
        check(rx_oe_n === 1'b1 && acq_oe_n === 1'b0 && acq_n === 1'b0, "rx disable");
        rx_en = 1'b1;
        repeat (6) @(negedge ref_clk);
        check(rx_oe_n === 1'b0, "rx enable");
        ser_en = 1'b0;
        repeat (24) @(negedge ref_clk);
        check(out_oe_n === 1'b1 && acq_n === 1'b0, "lock lost early");
        repeat (90) @(negedge ref_clk);
        check(acq_n === 1'b1 && rx_oe_n === 1'b1, "lock kept");
        $display("test output controls done");
        {tx_pd_n, rx_pd_n, ser_en} = 3'h1;
        repeat (6) @(negedge ref_clk);
        check(out_oe_n === 1'b1 && acq_oe_n === 1'b1 && rx_oe_n === 1'b1, "awake");
        $display("test power down done");
        // Bypass bit follows data in over one test clock pulse pair
        foreach (corner[i]) begin
            tdi = corner[i][0];
            repeat (4) @(negedge ref_clk) tck = ~tck;
            repeat (4) @(negedge ref_clk);
            check(tdo === tdi && tdo_oe_n === 1'b0, "scan bypass");
        end
        trst_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        check(tdo === 1'b0 && tdo_oe_n === 1'b1, "scan reset");
        $display("test scan bypass done");
        test_done();
    end
endmodule
`default_nettype wire
